// ---- logic/asr_map.svh ----
// register offsets, reset values, opcodes and timing counts
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_CTRL_OFS 12'h000
`define ASR_STAT_OFS 12'h004
`define ASR_LAST_OFS 12'h008
`define ASR_FSEL_LSB 0
`define ASR_FSEL_RST 2'h2
`define ASR_FSEL_MOD 2'h0
`define ASR_FSEL_SINC 2'h1
`define ASR_OP_RDC 8'h10
`define ASR_OP_SDC 8'h11
`define ASR_OP_RD 8'h12
`define ASR_OP_WAKE 7'h00
`define ASR_OP_STBY 7'h01
`define ASR_CLIP_POS 32'h7fffffff
`define ASR_CLIP_NEG 32'h80000000
`define ASR_UPDATE_CLKS 3'h4
`define ASR_TIMEOUT_CONV 7'h40
`define ASR_MCLK_DLY 3'h5
`define ASR_MOD_SETTLE 5'h10
`define ASR_WORD_BITS 6'h20
`endif

// ---- logic/asr_pkg.sv ----
// types shared by the serial readout block
package asr_pkg;
   typedef enum logic [1:0] {
      ASR_IDLE,
      ASR_UPDATE,
      ASR_READY
   } asr_rdy_e;
   typedef logic [31:0] asr_word_t;
endpackage

// ---- logic/asr_readout.sv ----
// conversion result serial readout with modulator stream output
//
// Overview of operation
// - result_ready_n falls whenever a fresh result becomes readable.
// - command mode: a read may overlap next ready without corruption.
// - result_ready_n returns high on first serial clock falling edge.
// - unread results: ready pulses high four clocks per update, then low.
// - word is 32-bit twos complement, LSB repeats the sign on the unclipped FIR path.
// - FIR clipping gives 7fffffff positive, 80000000 negative.
// - sinc path halves the word and never clips.
// - continuous mode at reset and after cmd_read_continuous.
// - MSB on data out at ready fall, zeros beyond 32 bits.
// - cmd_stop_continuous suppresses ready; results read by command only.
// - read opcode taken at eighth rising edge, data at next ready fall.
// - filter_select 00 turns modulator pins into outputs.
// - modulator clock runs at a quarter of the master clock.
// - sync resets modulator clock, next rise five clocks later.
// - modulator stream held low after sync, valid from the 18th modulator clock rise.
// - modulator data leaves as two bits for the receiver to merge.
// - data in captured on rising, data out changed on falling edges.
// - serial clock low for 64 updates resets the serial interface.
// - opcodes 10h continuous, 11h stop, 12h read by command.
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_readout (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_strobe,
   input wire logic [30:0] conv_value,
   input wire logic conv_over_pos,
   input wire logic conv_over_neg,
   input wire logic [1:0] mod_bits,
   input wire logic sclk,
   input wire logic din,
   input wire logic sync_pin,
   output logic dout,
   output logic result_ready_n,
   output logic mod_clk_out,
   output logic mod_clk_oe,
   output logic mod_stream_bit_a,
   output logic mod_stream_bit_a_oe,
   output logic mod_stream_bit_b,
   output logic mod_stream_bit_b_oe
);
   // word formatting: sign repeated in LSB, clip or halve by path
   function automatic asr_pkg::asr_word_t fmt(
      input logic sinc, input logic [30:0] v,
      input logic opos, input logic oneg);
      asr_pkg::asr_word_t w;
      w = {v, v[30]};
      if (sinc)
         w = {v[30], v};
      else if (opos)
         w = `ASR_CLIP_POS;
      else if (oneg)
         w = `ASR_CLIP_NEG;
      return w;
   endfunction

   // pin synchronisers
   logic [2:0] sclk_sy;
   logic [1:0] din_sy;
   logic [2:0] sync_sy;
   always_ff @(posedge clk) begin
      sclk_sy <= {sclk_sy[1:0], sclk};
      din_sy <= {din_sy[0], din};
      sync_sy <= {sync_sy[1:0], sync_pin};
   end
   wire sclk_rise = sclk_sy[1] & ~sclk_sy[2];
   wire sclk_fall = ~sclk_sy[1] & sclk_sy[2];
   wire sync_evt = sync_sy[1] & ~sync_sy[2];

   // apb slave, zero wait states
   logic [1:0] fsel_reg;
   logic [1:0] fsel_next;
   asr_pkg::asr_word_t last_reg;
   logic cont_reg;
   logic stby_reg;
   logic armed_reg;
   wire setup = psel & ~penable;
   wire hit_ctrl = paddr == `ASR_CTRL_OFS;
   wire hit_stat = paddr == `ASR_STAT_OFS;
   wire hit_last = paddr == `ASR_LAST_OFS;
   wire mapped = hit_ctrl | hit_stat | hit_last;
   wire wr_ctrl = psel & penable & pready & pwrite & hit_ctrl;
   wire mod_mode = fsel_reg == `ASR_FSEL_MOD;
   wire sinc_mode = fsel_reg == `ASR_FSEL_SINC;
   wire [31:0] stat_val = {28'h0, mod_mode, armed_reg, stby_reg, cont_reg};
   wire [31:0] rd_mux = hit_ctrl ? {30'h0, fsel_reg} :
                        hit_stat ? stat_val :
                        hit_last ? last_reg : 32'h0;
   assign fsel_next = wr_ctrl ? pwdata[`ASR_FSEL_LSB +: 2] : fsel_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         fsel_reg <= `ASR_FSEL_RST;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup ? rd_mux : 32'h0;
         fsel_reg <= fsel_next;
      end
   end

   // command byte receiver, bits taken on serial clock rise
   logic [7:0] cmd_sh;
   logic [2:0] cmd_cnt;
   logic [6:0] to_cnt;
   wire [7:0] cmd_byte = {cmd_sh[6:0], din_sy[1]};
   wire byte_done = sclk_rise & (cmd_cnt == 3'h7);
   wire op_rdc = byte_done & (cmd_byte == `ASR_OP_RDC);
   wire op_sdc = byte_done & (cmd_byte == `ASR_OP_SDC);
   wire op_rd = byte_done & (cmd_byte == `ASR_OP_RD);
   wire op_wake = byte_done & (cmd_byte[7:1] == `ASR_OP_WAKE);
   wire op_stby = byte_done & (cmd_byte[7:1] == `ASR_OP_STBY);
   wire timeout = to_cnt == `ASR_TIMEOUT_CONV;
   wire conv_ok = conv_strobe & ~stby_reg & ~mod_mode;
   always_ff @(posedge clk) begin
      if (rst | timeout) begin
         cmd_sh <= 8'h0;
         cmd_cnt <= 3'h0;
      end else if (sclk_rise) begin
         cmd_sh <= cmd_byte;
         cmd_cnt <= cmd_cnt + 3'h1;
      end
   end

   // idle watchdog counts updates while serial clock stays low
   always_ff @(posedge clk) begin
      if (rst | sclk_sy[1] | sclk_fall | timeout)
         to_cnt <= 7'h0;
      else if (conv_strobe)
         to_cnt <= to_cnt + 7'h1;
   end

   // read mode, standby and pending read request
   logic rdy_load;
   always_ff @(posedge clk) begin
      if (rst) begin
         cont_reg <= 1'b1;
         stby_reg <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         if (op_rdc)
            cont_reg <= 1'b1;
         else if (op_sdc)
            cont_reg <= 1'b0;
         if (op_stby)
            stby_reg <= 1'b1;
         else if (op_wake)
            stby_reg <= 1'b0;
         // a new request wins over the load that consumes the old one
         if (op_rd & ~cont_reg)
            armed_reg <= 1'b1;
         else if (rdy_load | timeout)
            armed_reg <= 1'b0;
      end
   end

   // ready strobe sequencing
   asr_pkg::asr_rdy_e st_reg;
   asr_pkg::asr_rdy_e st_next;
   logic [2:0] upd_cnt;
   asr_pkg::asr_word_t pend_reg;
   wire upd_end = (st_reg == asr_pkg::ASR_UPDATE) & (upd_cnt == 3'h1);
   assign rdy_load = upd_end & (cont_reg | armed_reg);
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         asr_pkg::ASR_IDLE:
            if (conv_ok)
               st_next = asr_pkg::ASR_UPDATE;
         asr_pkg::ASR_UPDATE:
            if (upd_end)
               st_next = rdy_load ? asr_pkg::ASR_READY : asr_pkg::ASR_IDLE;
         asr_pkg::ASR_READY:
            if (conv_ok)
               st_next = asr_pkg::ASR_UPDATE;
         default:
            st_next = asr_pkg::ASR_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= asr_pkg::ASR_IDLE;
         upd_cnt <= 3'h0;
         result_ready_n <= 1'b1;
         pend_reg <= 32'h0;
         last_reg <= 32'h0;
      end else begin
         st_reg <= st_next;
         if (conv_ok) begin
            upd_cnt <= `ASR_UPDATE_CLKS;
            result_ready_n <= 1'b1;
            pend_reg <= fmt(sinc_mode, conv_value, conv_over_pos,
                            conv_over_neg);
         end else if (st_reg == asr_pkg::ASR_UPDATE) begin
            upd_cnt <= upd_cnt - 3'h1;
            if (rdy_load) begin
               result_ready_n <= 1'b0;
               last_reg <= pend_reg;
            end
         end else if (sclk_fall) begin
            result_ready_n <= 1'b1;
         end
      end
   end

   // output shifter, changes on serial clock fall
   asr_pkg::asr_word_t out_sh;
   logic [5:0] out_cnt;
   always_ff @(posedge clk) begin
      if (rst | timeout) begin
         out_sh <= 32'h0;
         out_cnt <= `ASR_WORD_BITS;
         dout <= 1'b0;
      end else if (rdy_load) begin
         // overwrites any partial read
         out_sh <= pend_reg;
         out_cnt <= 6'h0;
         dout <= pend_reg[31];
      end else if (sclk_fall) begin
         out_sh <= {out_sh[30:0], 1'b0};
         if (out_cnt != `ASR_WORD_BITS)
            out_cnt <= out_cnt + 6'h1;
         dout <= (out_cnt < `ASR_WORD_BITS - 6'h1) & out_sh[30];
      end
   end

   // modulator clock divider with sync phase reset
   logic [1:0] ph_reg;
   logic [2:0] sdly_reg;
   logic [4:0] settle_reg;
   wire mclk_rise = (sdly_reg == 3'h1) |
                    ((sdly_reg == 3'h0) & (ph_reg == 2'h1));
   always_ff @(posedge clk) begin
      if (rst) begin
         ph_reg <= 2'h0;
         sdly_reg <= 3'h0;
         settle_reg <= `ASR_MOD_SETTLE;
         mod_clk_out <= 1'b0;
      end else if (sync_evt) begin
         sdly_reg <= `ASR_MCLK_DLY;
         settle_reg <= 5'h0;
         mod_clk_out <= 1'b0;
      end else if (sdly_reg != 3'h0) begin
         sdly_reg <= sdly_reg - 3'h1;
         // parked so the first high after restart lasts two clocks
         ph_reg <= 2'h2;
         mod_clk_out <= sdly_reg == 3'h1;
      end else begin
         ph_reg <= ph_reg + 2'h1;
         mod_clk_out <= ~ph_reg[0] ^ ph_reg[1] ? 1'b0 : 1'b1;
         if (mclk_rise & (settle_reg != `ASR_MOD_SETTLE))
            settle_reg <= settle_reg + 5'h1;
      end
   end

   // modulator data pins
   always_ff @(posedge clk) begin
      if (rst) begin
         mod_stream_bit_a <= 1'b0;
         mod_stream_bit_b <= 1'b0;
         mod_clk_oe <= 1'b0;
         mod_stream_bit_a_oe <= 1'b0;
         mod_stream_bit_b_oe <= 1'b0;
      end else begin
         mod_clk_oe <= mod_mode;
         mod_stream_bit_a_oe <= mod_mode;
         mod_stream_bit_b_oe <= mod_mode;
         if (sync_evt) begin
            // restart drops the old stream at once
            mod_stream_bit_a <= 1'b0;
            mod_stream_bit_b <= 1'b0;
         end else if (mclk_rise) begin
            // held low until the stream has settled
            mod_stream_bit_a <= mod_mode & (settle_reg ==
                                `ASR_MOD_SETTLE) & mod_bits[0];
            mod_stream_bit_b <= mod_mode & (settle_reg ==
                                `ASR_MOD_SETTLE) & mod_bits[1];
         end
      end
   end
endmodule

// ---- test/asr_host.sv ----
// host model driving the serial link of the readout block
`timescale 1ns/1ns
module asr_host (
   input wire logic clk,
   input wire logic dout,
   output logic sclk,
   output logic din
);
   initial begin
      sclk = 1'b0;
      din = 1'b0;
   end
   // din set while sclk low, dout taken at each rise
   task automatic shift(input int n, input logic [39:0] tx,
         output logic [39:0] rx);
      rx = '0;
      for (int i = 0; i < n; i++) begin
         din <= tx[39 - i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         rx = {rx[38:0], dout};
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      din <= 1'b0;
      repeat (30) @(posedge clk);
   endtask
endmodule

// ---- test/asr_readout_assertions.sv ----
// port checks of the serial readout block
`timescale 1ns/1ns
module asr_readout_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_strobe,
   input wire logic sclk,
   input wire logic sync_pin,
   input wire logic result_ready_n,
   input wire logic mod_clk_out,
   input wire logic mod_clk_oe,
   input wire logic mod_stream_bit_a,
   input wire logic mod_stream_bit_b
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_mck_high; mod_clk_out [*2]; endsequence
   sequence s_mck_low; !mod_clk_out [*2]; endsequence
   property p_ready_fall; $fell(result_ready_n) |->
      $past(conv_strobe, 5) && $past(result_ready_n, 4); endproperty
   a_ready_fall: assert property (p_ready_fall)
      else $error("ready fell without an update");
   property p_unread; conv_strobe && !result_ready_n |=>
      result_ready_n [*4] ##1 !result_ready_n; endproperty
   a_unread: assert property (p_unread)
      else $error("ready pulse not four cycles");
   property p_release; $fell(sclk) && !result_ready_n |->
      ##[1:5] result_ready_n; endproperty
   a_release: assert property (p_release)
      else $error("ready not released by serial clock fall");
   property p_mck_period; disable iff (rst || sync_pin || !mod_clk_oe)
      $rose(mod_clk_out) |-> s_mck_high ##1 s_mck_low ##1 mod_clk_out;
   endproperty
   a_mck_period: assert property (p_mck_period)
      else $error("modulator clock not a quarter rate");
   property p_sync; $rose(sync_pin) && mod_clk_oe |->
      ##3 s_mck_low ##1 s_mck_low ##1 !mod_clk_out ##1 mod_clk_out;
   endproperty
   a_sync: assert property (p_sync)
      else $error("modulator clock not restarted by sync");
   property p_settle; $rose(sync_pin) && mod_clk_oe |->
      ##4 (!mod_stream_bit_a && !mod_stream_bit_b) [*8]; endproperty
   a_settle: assert property (p_settle)
      else $error("stream not held after sync");
   property p_apb_answer; psel && !penable |=> pready; endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("no answer in access cycle");
   property p_apb_err; pslverr |-> pready; endproperty
   a_apb_err: assert property (p_apb_err)
      else $error("error flag outside access cycle");
endmodule
bind asr_readout asr_readout_assertions u_chk (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .conv_strobe(conv_strobe), .sclk(sclk), .sync_pin(sync_pin),
   .result_ready_n(result_ready_n), .mod_clk_out(mod_clk_out),
   .mod_clk_oe(mod_clk_oe), .mod_stream_bit_a(mod_stream_bit_a),
   .mod_stream_bit_b(mod_stream_bit_b));

// ---- test/asr_readout_tb.sv ----
// self-checking bench for the serial readout block
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_readout_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, dout, rdy_n, er;
   logic conv_strobe, conv_over_pos, conv_over_neg, sclk, din, sync_pin;
   logic mck, mck_oe, ma, ma_oe, mb, mb_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [30:0] conv_value;
   logic [1:0] mod_bits;
   logic [39:0] rx;
   logic [30:0] vt [4] = '{31'h1234, 31'h7fff0000, 31'h1, 31'h0};
   logic [31:0] et [4] = '{32'h2468, 32'hfffe0001, 32'h7fffffff,
      32'h80000000};
   int errors = 0, cmp_count = 0;
   asr_readout uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_strobe(conv_strobe),
      .conv_value(conv_value), .conv_over_pos(conv_over_pos),
      .conv_over_neg(conv_over_neg), .mod_bits(mod_bits), .sclk(sclk),
      .din(din), .sync_pin(sync_pin), .dout(dout), .result_ready_n(rdy_n),
      .mod_clk_out(mck), .mod_clk_oe(mck_oe), .mod_stream_bit_a(ma),
      .mod_stream_bit_a_oe(ma_oe), .mod_stream_bit_b(mb),
      .mod_stream_bit_b_oe(mb_oe));
   asr_host host (.clk(clk), .dout(dout), .sclk(sclk), .din(din));
   always #10 clk = ~clk;
   task automatic chk(input string nm, input logic [39:0] e, g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic conv(input logic [30:0] v, input logic p, ng);
      @(posedge clk);
      conv_value <= v;
      conv_over_pos <= p;
      conv_over_neg <= ng;
      conv_strobe <= 1'b1;
      @(posedge clk);
      conv_strobe <= 1'b0;
   endtask
   // ready is settled well after the four-cycle update
   task automatic wait_rdy(input logic e);
      repeat (8) @(posedge clk);
      chk("ready", e, rdy_n);
   endtask
   task report_and_stop;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {clk, psel, penable, pwrite, conv_strobe, sync_pin} = '0;
      {conv_over_pos, conv_over_neg, mod_bits} = '0;
      {paddr, pwdata, conv_value} = '0;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `ASR_STAT_OFS, 32'h0);
      chk("stat", 32'h1, rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk("slverr", 1'b1, er);
      for (int i = 0; i < 4; i++) begin
         conv(vt[i], i == 2, i == 3);
         wait_rdy(1'b0);
         chk("msb", et[i][31], dout);
         host.shift(40, 40'h0, rx);
         chk("word", {et[i], 8'h0}, rx);
         chk("ready", 1'b1, rdy_n);
      end
      apb(1'b0, `ASR_LAST_OFS, 32'h0);
      chk("last", 32'h80000000, rd);
      conv(31'h10, 1'b0, 1'b0);
      wait_rdy(1'b0);
      conv(31'h12345678, 1'b0, 1'b0);
      wait_rdy(1'b0);
      host.shift(24, 40'h0, rx);
      chk("part", 24'h2468ac, rx);
      conv(31'h1, 1'b0, 1'b0);
      wait_rdy(1'b0);
      host.shift(32, 40'h0, rx);
      chk("next", 32'h2, rx);
      apb(1'b1, `ASR_CTRL_OFS, 32'h1);
      apb(1'b0, `ASR_CTRL_OFS, 32'h0);
      chk("ctrl", 32'h1, rd);
      conv(31'h40000001, 1'b1, 1'b0);
      wait_rdy(1'b0);
      host.shift(32, 40'h0, rx);
      chk("sinc", 32'hc0000001, rx);
      apb(1'b1, `ASR_CTRL_OFS, 32'h2);
      host.shift(8, {8'h11, 32'h0}, rx);
      conv(31'h5, 1'b0, 1'b0);
      wait_rdy(1'b1);
      host.shift(8, {8'h12, 32'h0}, rx);
      conv(31'h0f0f0f0f, 1'b0, 1'b0);
      wait_rdy(1'b0);
      fork
         host.shift(32, 40'h0, rx);
         begin
            repeat (16) @(posedge clk);
            conv(31'h7, 1'b0, 1'b0);
         end
      join
      chk("cmd", 32'h1e1e1e1e, rx);
      host.shift(8, {8'h10, 32'h0}, rx);
      host.shift(8, {8'h02, 32'h0}, rx);
      conv(31'h9, 1'b0, 1'b0);
      wait_rdy(1'b1);
      host.shift(8, 40'h0, rx);
      conv(31'h9, 1'b0, 1'b0);
      wait_rdy(1'b0);
      host.shift(32, 40'h0, rx);
      chk("shot", 32'h12, rx);
      host.shift(3, 40'h0, rx);
      repeat (64) begin
         conv(31'h3, 1'b0, 1'b0);
         repeat (6) @(posedge clk);
      end
      host.shift(8, {8'h11, 32'h0}, rx);
      apb(1'b0, `ASR_STAT_OFS, 32'h0);
      chk("abort", 32'h0, rd);
      host.shift(8, {8'h10, 32'h0}, rx);
      mod_bits <= 2'b10;
      apb(1'b1, `ASR_CTRL_OFS, 32'h0);
      apb(1'b0, `ASR_STAT_OFS, 32'h0);
      chk("mode", 32'h9, rd);
      chk("oe", 3'b111, {mck_oe, ma_oe, mb_oe});
      sync_pin <= 1'b1;
      repeat (12) @(posedge clk);
      sync_pin <= 1'b0;
      repeat (100) @(posedge clk);
      chk("stream", 2'b10, {mb, ma});
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop;
   end
endmodule
